// ### src/ccl_top.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ccl_top (
	input  wire logic                  mclk,          // System clock, 25 MHz.
	input  wire logic                  rst_n,         // Async reset, active low.
	input  wire logic                  clk_en,        // Freezes all state when low.
	input  wire logic [ccl_pkg::ADDR_W-1:0] s_axi_awaddr,  // Write address.
	input  wire logic                  s_axi_awvalid, // Write address valid.
	output logic                       s_axi_awready, // Write address ready.
	input  wire logic [ccl_pkg::DATA_W-1:0] s_axi_wdata,   // Write data.
	input  wire logic [3:0]            s_axi_wstrb,   // Write strobes.
	input  wire logic                  s_axi_wvalid,  // Write data valid.
	output logic                       s_axi_wready,  // Write data ready.
	output logic [1:0]                 s_axi_bresp,   // Write response.
	output logic                       s_axi_bvalid,  // Write response valid.
	input  wire logic                  s_axi_bready,  // Write response ready.
	input  wire logic [ccl_pkg::ADDR_W-1:0] s_axi_araddr,  // Read address.
	input  wire logic                  s_axi_arvalid, // Read address valid.
	output logic                       s_axi_arready, // Read address ready.
	output logic [ccl_pkg::DATA_W-1:0] s_axi_rdata,   // Read data.
	output logic [1:0]                 s_axi_rresp,   // Read response.
	output logic                       s_axi_rvalid,  // Read valid.
	input  wire logic                  s_axi_rready,  // Read ready.
	input  wire logic                  cmp_raw,       // Raw comparator result.
	input  wire logic                  vector_ack,    // Vector taken, one pulse.
	input  wire ccl_pkg::ccl_pin_pair_t pin_raw,      // Digital pin levels.
	output ccl_pkg::ccl_pin_pair_t     pin_read,      // Gated pin read bits.
	output ccl_pkg::ccl_analog_ctl_t   analog_ctl,    // Analog controls.
	output logic                       capture_in,    // To capture front end.
	output logic                       cmp_irq,       // Comparator irq request.
	output logic                       irq            // Status-register irq.
);
	import ccl_pkg::*;

	// Register bytes, status flags and comparator sync state.
	logic [7:0] ctrl;
	logic [7:0] conv_b;
	logic [7:0] conv_a;
	logic [7:0] chan_sel;
	logic [1:0] pin_off;
	logic [7:0] core_status;
	logic [NUM_IRQ-1:0] irq_status;
	logic [NUM_IRQ-1:0] irq_enable;
	logic       evt_flag;
	logic       sync_meta;
	logic       sync_out;
	logic       prev_out;

	// Write channel holding registers.
	logic                  aw_held;
	logic                  w_held;
	logic [ADDR_W-1:0]     aw_addr;
	logic [DATA_W-1:0]     w_data;
	logic [3:0]            w_strb;

	// Decodes a byte address to a known register.
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == ADDR_CTRL_STATUS) || (a == ADDR_CONV_CTRL_B) ||
			(a == ADDR_CONV_CTRL_A) || (a == ADDR_CHAN_SEL) ||
			(a == ADDR_PIN_DISABLE) || (a == ADDR_CORE_STATUS) ||
			(a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_ENABLE) ||
			(a == ADDR_IRQ_CLEAR);
	endfunction : is_mapped

	// Write happens when both halves are held and no response is pending.
	wire       wr_fire  = aw_held && w_held && !s_axi_bvalid;
	wire       wr_lane0 = wr_fire && w_strb[0];
	wire [7:0] wbyte    = w_data[7:0];
	wire       wr_ctrl  = wr_lane0 && (aw_addr == ADDR_CTRL_STATUS);
	wire       wr_convb = wr_lane0 && (aw_addr == ADDR_CONV_CTRL_B);
	wire       wr_conva = wr_lane0 && (aw_addr == ADDR_CONV_CTRL_A);
	wire       wr_chan  = wr_lane0 && (aw_addr == ADDR_CHAN_SEL);
	wire       wr_pin   = wr_lane0 && (aw_addr == ADDR_PIN_DISABLE);
	wire       wr_core  = wr_lane0 && (aw_addr == ADDR_CORE_STATUS);
	wire       wr_ien   = wr_lane0 && (aw_addr == ADDR_IRQ_ENABLE);
	wire       wr_iclr  = wr_lane0 && (aw_addr == ADDR_IRQ_CLEAR);

	// Mode decode and edge classification.
	wire ccl_mode_t mode = ccl_mode_t'(ctrl[BIT_MODE_HI:BIT_MODE_LO]);
	wire rise   = sync_out && !prev_out;
	wire fall   = !sync_out && prev_out;
	wire toggle = sync_out ^ prev_out;
	logic evt_hit;

	always_comb begin
		unique case (mode)
			CCL_MODE_TOGGLE:   evt_hit = toggle;
			CCL_MODE_RESERVED: evt_hit = 1'b0;
			CCL_MODE_FALL:     evt_hit = fall;
			CCL_MODE_RISE:     evt_hit = rise;
		endcase
	end

	// Flag clear sources; the hardware set wins over either clear.
	wire flag_clr = vector_ack || (wr_ctrl && wbyte[BIT_EVT_FLAG]);
	wire [NUM_IRQ-1:0] irq_evt = {toggle, evt_hit};
	wire [NUM_IRQ-1:0] irq_clr = wr_iclr ? wbyte[NUM_IRQ-1:0] : '0;

	wire neg_mux = conv_b[BIT_MUX_EN] && !conv_a[BIT_CONV_ON];

	// Read data decode.
	logic [7:0] ctrl_rd;
	always_comb begin
		ctrl_rd = ctrl;
		ctrl_rd[BIT_OUT_STATUS] = sync_out;
		ctrl_rd[BIT_EVT_FLAG] = evt_flag;
	end
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = RESET_BYTE;
		unique case (s_axi_araddr)
			ADDR_CTRL_STATUS: rd_byte = ctrl_rd;
			ADDR_CONV_CTRL_B: rd_byte = conv_b;
			ADDR_CONV_CTRL_A: rd_byte = conv_a;
			ADDR_CHAN_SEL:    rd_byte = chan_sel;
			ADDR_PIN_DISABLE: rd_byte = {6'h00, pin_off};
			ADDR_CORE_STATUS: rd_byte = core_status;
			ADDR_IRQ_STATUS:  rd_byte = {6'h00, irq_status};
			ADDR_IRQ_ENABLE:  rd_byte = {6'h00, irq_enable};
			default:          rd_byte = RESET_BYTE;
		endcase
	end

	// Write address and data capture, in either order.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else if (clk_en) begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_byte};
				s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Software control registers.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl        <= RESET_BYTE;
			conv_b      <= RESET_BYTE;
			conv_a      <= RESET_BYTE;
			chan_sel    <= RESET_BYTE;
			pin_off     <= '0;
			core_status <= RESET_BYTE;
			irq_enable  <= '0;
		end else if (clk_en) begin
			if (wr_ctrl) ctrl <= wbyte;
			if (wr_convb) conv_b <= wbyte;
			if (wr_conva) conv_a <= wbyte;
			if (wr_chan) chan_sel <= wbyte;
			if (wr_pin) pin_off <= wbyte[BIT_NEG_OFF:BIT_POS_OFF];
			if (wr_core) core_status <= wbyte;
			if (wr_ien) irq_enable <= wbyte[NUM_IRQ-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta <= 1'b0;
			sync_out  <= 1'b0;
			prev_out  <= 1'b0;
		end else if (clk_en) begin
			sync_meta <= cmp_raw;
			sync_out  <= sync_meta;
			prev_out  <= sync_out;
		end
	end

	// event flag set, set beats clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			evt_flag <= 1'b0;
		end else if (clk_en) begin
			if (evt_hit) evt_flag <= 1'b1;
			else if (flag_clr) evt_flag <= 1'b0;
		end
	end

	// Sticky status bits, set winning over clear.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					irq_status[gi] <= 1'b0;
				end else if (clk_en) begin
					if (irq_evt[gi]) irq_status[gi] <= 1'b1;
					else if (irq_clr[gi]) irq_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Registered outputs toward analog core, pins, capture and cpu.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			analog_ctl <= '0;
			pin_read   <= '0;
			capture_in <= 1'b0;
			cmp_irq    <= 1'b0;
			irq        <= 1'b0;
		end else if (clk_en) begin
			analog_ctl.power_off    <= ctrl[BIT_POWER_OFF];
			analog_ctl.pos_bandgap  <= ctrl[BIT_BANDGAP];
			analog_ctl.neg_from_mux <= neg_mux;
			analog_ctl.neg_channel  <= chan_sel[BIT_CHAN_LO +: CHAN_W];
			analog_ctl.neg_pin_input_off <= pin_off[BIT_NEG_OFF];
			analog_ctl.pos_pin_input_off <= pin_off[BIT_POS_OFF];
			pin_read.negative_pin <= pin_raw.negative_pin && !pin_off[BIT_NEG_OFF];
			pin_read.positive_pin <= pin_raw.positive_pin && !pin_off[BIT_POS_OFF];
			capture_in <= ctrl[BIT_CAPTURE] && sync_out;
			cmp_irq <= evt_flag && ctrl[BIT_IRQ_EN] && core_status[BIT_GLOBAL_IE];
			irq     <= |(irq_status & irq_enable);
		end
	end

endmodule : ccl_top
`default_nettype wire

// ### src/ccl_pkg.sv
package ccl_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CTRL_STATUS = 8'h50;
	localparam logic [ADDR_W-1:0] ADDR_CONV_CTRL_B = 8'h54;
	localparam logic [ADDR_W-1:0] ADDR_CONV_CTRL_A = 8'h58;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_SEL    = 8'h5C;
	localparam logic [ADDR_W-1:0] ADDR_PIN_DISABLE = 8'h60;
	localparam logic [ADDR_W-1:0] ADDR_CORE_STATUS = 8'h64;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 8'h68;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE  = 8'h6C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR   = 8'h70;

	// Field positions and widths in the control and status register and the other registers.
	localparam int BIT_POWER_OFF  = 7;
	localparam int BIT_BANDGAP    = 6;
	localparam int BIT_OUT_STATUS = 5;
	localparam int BIT_EVT_FLAG   = 4;
	localparam int BIT_IRQ_EN     = 3;
	localparam int BIT_CAPTURE    = 2;
	localparam int BIT_MODE_HI    = 1;
	localparam int BIT_MODE_LO    = 0;
	localparam int BIT_MUX_EN     = 6;
	localparam int BIT_CONV_ON    = 7;
	localparam int BIT_GLOBAL_IE  = 7;
	localparam int BIT_NEG_OFF    = 1;
	localparam int BIT_POS_OFF    = 0;
	localparam int BIT_CHAN_LO    = 0;
	localparam int CHAN_W         = 3;
	localparam int NUM_CHAN       = 8;
	localparam int NUM_IRQ        = 2;
	localparam int IRQ_EVENT      = 0;
	localparam int IRQ_EDGE       = 1;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Interrupt event modes.
	typedef enum logic [1:0] {
		CCL_MODE_TOGGLE   = 2'b00,
		CCL_MODE_RESERVED = 2'b01,
		CCL_MODE_FALL     = 2'b10,
		CCL_MODE_RISE     = 2'b11
	} ccl_mode_t;

	// Analog side control bundle.
	typedef struct packed {
		logic             power_off;
		logic             pos_bandgap;
		logic             neg_from_mux;
		logic [CHAN_W-1:0] neg_channel;
		logic             neg_pin_input_off;
		logic             pos_pin_input_off;
	} ccl_analog_ctl_t;

	// Pin digital read bundle.
	typedef struct packed {
		logic negative_pin;
		logic positive_pin;
	} ccl_pin_pair_t;

endpackage : ccl_pkg

// ### testbench/ccl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ccl_chk (
	input wire logic                    mclk,          // Clock.
	input wire logic                    rst_n,         // Reset, active low.
	input wire logic                    s_axi_bvalid,  // Write answer.
	input wire logic                    s_axi_bready,  // Write answer taken.
	input wire logic                    s_axi_arvalid, // Read request.
	input wire logic                    s_axi_arready, // Read accepted.
	input wire logic [31:0]             s_axi_rdata,   // Read data.
	input wire logic                    s_axi_rvalid,  // Read answer.
	input wire logic                    s_axi_rready,  // Read answer taken.
	input wire logic                    cmp_raw,       // Raw comparator.
	input wire logic                    vector_ack,    // Vector taken.
	input wire ccl_pkg::ccl_pin_pair_t  pin_read,      // Gated pin reads.
	input wire ccl_pkg::ccl_analog_ctl_t analog_ctl,   // Analog controls.
	input wire logic                    capture_in,    // Capture feed.
	input wire logic                    cmp_irq        // Comparator irq.
);
	import ccl_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// The comparator input has been steady for five cycles.
	sequence s_quiet;
		$stable(cmp_raw) [*5];
	endsequence
	// Bus answers stand until the master takes them.
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	// Read address is taken one cycle after it is offered.
	property p_ar_take;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready;
	endproperty
	a_ar_take: assert property (p_ar_take) else $error("read not taken");
	property p_r_after;
		$rose(s_axi_rvalid) |-> $past(s_axi_arready);
	endproperty
	a_r_after: assert property (p_r_after) else $error("read answer early");
	property p_rdata_byte;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rdata_byte: assert property (p_rdata_byte) else $error("upper bits set");
	// Disabled pin buffers read zero.
	property p_pin_neg;
		analog_ctl.neg_pin_input_off |-> !pin_read.negative_pin;
	endproperty
	a_pin_neg: assert property (p_pin_neg) else $error("neg pin not gated");
	property p_pin_pos;
		analog_ctl.pos_pin_input_off |-> !pin_read.positive_pin;
	endproperty
	a_pin_pos: assert property (p_pin_pos) else $error("pos pin not gated");
	// A low steady comparator never reaches the capture unit.
	property p_cap_low;
		s_quiet ##0 !cmp_raw |-> !capture_in;
	endproperty
	a_cap_low: assert property (p_cap_low) else $error("capture without cause");
	// Taking the vector drops the request two cycles later.
	property p_ack_clear;
		s_quiet ##0 (vector_ack && cmp_irq) |-> ##2 !cmp_irq;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("irq not cleared");
endmodule : ccl_chk
bind ccl_top ccl_chk ccl_chk_inst (.*);
`default_nettype wire

// ### testbench/ccl_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module ccl_analog_model #(
	parameter logic [7:0] BANDGAP_LVL = 8'h80 // Reference level.
) (
	input wire ccl_pkg::ccl_analog_ctl_t analog_ctl, // Analog controls.
	input wire logic [7:0]               pos_lvl,    // Positive pin level.
	input wire logic [7:0]               neg_lvl,    // Negative pin level.
	input wire logic [63:0]              chan_lvl,   // Channel levels.
	output logic                         cmp_raw     // Raw result.
);
	import ccl_pkg::*;
	logic [7:0] pos_sel;
	logic [7:0] neg_sel;
	assign pos_sel = analog_ctl.pos_bandgap ? BANDGAP_LVL : pos_lvl;
	assign neg_sel = analog_ctl.neg_from_mux ?
		chan_lvl[analog_ctl.neg_channel*8 +: 8] : neg_lvl;
	assign cmp_raw = !analog_ctl.power_off && (pos_sel > neg_sel);
endmodule : ccl_analog_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ccl_pkg::*;
	logic mclk, rst_n, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, cmp_raw, vector_ack;
	logic capture_in, cmp_irq, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pos_lvl, neg_lvl;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [63:0] chan_lvl;
	ccl_pin_pair_t pin_raw, pin_read;
	ccl_analog_ctl_t analog_ctl;
	int n_mismatch, num_checks, cyc;
	ccl_top ccl_top_inst (.*);
	ccl_analog_model ccl_analog_model_inst (.*);
	// Clock and watchdog.
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge mclk);
	endtask : w
	// Bus write with both channels offered together.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(d, {24'h0, e});
		chk(r, RESP_OKAY);
	endtask : rchk
	task automatic cmpset(input logic b);
		pos_lvl <= b ? 8'h30 : 8'h10;
		w(6);
	endtask : cmpset
	task automatic t_reset();
		rchk(ADDR_CTRL_STATUS, 8'h00);
		rchk(ADDR_PIN_DISABLE, 8'h00);
		rd(8'h7C);
		chk(r, RESP_SLVERR);
		wr(8'h7C, 8'hFF);
		chk(r, RESP_SLVERR);
	endtask : t_reset
	task automatic t_route();
		logic [63:0] v;
		wr(ADDR_CONV_CTRL_B, 8'h40);
		for (int k = 0; k < 8; k++) begin
			v = 64'hF0F0F0F0F0F0F0F0;
			v[8*k +: 8] = 8'h08;
			chan_lvl <= v;
			wr(ADDR_CHAN_SEL, k[7:0]);
			// The output rises on the first pass and dips on each later one; the flag stands.
			rchk(ADDR_CTRL_STATUS, 8'h30);
		end
		wr(ADDR_CONV_CTRL_A, 8'h80);
		rchk(ADDR_CTRL_STATUS, 8'h10);
		wr(ADDR_CONV_CTRL_A, 8'h00);
		wr(ADDR_CONV_CTRL_B, 8'h00);
		wr(ADDR_CTRL_STATUS, 8'h40);
		rchk(ADDR_CTRL_STATUS, 8'h70);
	endtask : t_route
	task automatic t_modes();
		// Drop the bandgap and bring the output low in the reserved mode.
		wr(ADDR_CTRL_STATUS, 8'h11);
		cmpset(1'b0);
		// irq enable stays clear while the mode changes.
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CTRL_STATUS, 8'h10 | m[7:0]);
			cmpset(1'b1);
			rchk(ADDR_CTRL_STATUS, {3'h1, m == 0 || m == 3, 2'h0, m[1:0]});
			wr(ADDR_CTRL_STATUS, 8'h10 | m[7:0]);
			cmpset(1'b0);
			rchk(ADDR_CTRL_STATUS, {3'h0, m == 0 || m == 2, 2'h0, m[1:0]});
		end
	endtask : t_modes
	task automatic t_irq();
		wr(ADDR_CORE_STATUS, 8'h80);
		wr(ADDR_CTRL_STATUS, 8'h1B);
		cmpset(1'b1);
		chk(cmp_irq, 1'b1);
		vector_ack <= 1'b1;
		@(posedge mclk);
		vector_ack <= 1'b0;
		w(3);
		chk(cmp_irq, 1'b0);
		cmpset(1'b0);
		cmpset(1'b1);
		wr(ADDR_CORE_STATUS, 8'h00);
		w(2);
		chk(cmp_irq, 1'b0);
		wr(ADDR_IRQ_ENABLE, 8'h02);
		w(2);
		chk(irq, 1'b1);
		wr(ADDR_IRQ_CLEAR, 8'h03);
		rchk(ADDR_IRQ_STATUS, 8'h00);
		chk(irq, 1'b0);
		cmpset(1'b0);
		chk(irq, 1'b1);
		wr(ADDR_IRQ_ENABLE, 8'h00);
		w(2);
		chk(irq, 1'b0);
		rchk(ADDR_IRQ_STATUS, 8'h02);
	endtask : t_irq
	// Clock enable low holds every flop, so a short pulse is never seen.
	task automatic t_freeze();
		clk_en <= 1'b0;
		cmpset(1'b1);
		cmpset(1'b0);
		clk_en <= 1'b1;
		rchk(ADDR_IRQ_STATUS, 8'h02);
	endtask : t_freeze
	task automatic t_misc();
		// the timer capture irq enable lies beyond this block.
		wr(ADDR_CTRL_STATUS, 8'h04);
		cmpset(1'b1);
		chk(capture_in, 1'b1);
		wr(ADDR_CTRL_STATUS, 8'h10);
		w(2);
		chk(capture_in, 1'b0);
		pin_raw <= 2'b11;
		wr(ADDR_PIN_DISABLE, 8'hFF);
		rchk(ADDR_PIN_DISABLE, 8'h03);
		chk(pin_read, 2'b00);
		wr(ADDR_PIN_DISABLE, 8'h02);
		w(2);
		chk(pin_read, 2'b01);
		// irq enable is already clear when power-off changes.
		wr(ADDR_CTRL_STATUS, 8'h90);
		w(6);
		chk(analog_ctl.power_off, 1'b1);
		rchk(ADDR_CTRL_STATUS, 8'h90);
	endtask : t_misc
	// Main sequence.
	initial begin
		{mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, vector_ack} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{clk_en, s_axi_wstrb, pin_raw} = 7'h7F;
		{pos_lvl, neg_lvl, chan_lvl} = {8'h10, 8'h20, 64'hF0F0F0F0F0F0F0F0};
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_route();
		t_modes();
		t_irq();
		t_freeze();
		t_misc();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
